// file: hdl/switch_drop_event_capture.sv
`timescale 1ns/1ns
`include "drop_capture_cfg.svh"

module switch_drop_event_capture
#(
  parameter int ADDR_W = 16                   // apb byte address width
)
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      drop_valid,
  input  wire drop_capture_pkg::reason_t drop_reason,
  input  wire drop_capture_pkg::port_t   drop_port,
  output logic                           drop_irq
);
  import drop_capture_pkg::*;

  // byte addresses derived from the register indices
  localparam logic [ADDR_W-1:0] STATUS_ADDR =
    ADDR_W'(`DES_STATUS_IDX << `DES_IDX_SHIFT);
  localparam logic [ADDR_W-1:0] MASK_ADDR =
    ADDR_W'(`DES_MASK_IDX << `DES_IDX_SHIFT);

  logic        pready_r;     // access phase marker, no wait state
  logic        pslverr_r;    // error answer for unmapped addresses
  logic [31:0] prdata_r;     // read word captured in the setup cycle
  logic        mask_r;       // interrupt mask, set out of reset
  logic        irq_r;        // registered interrupt request
  logic        snap_a_r;     // slot A was valid when the read was sampled
  logic        snap_b_r;     // slot B was valid when the read was sampled
  logic        setup;        // apb setup cycle
  logic        access_done;  // apb access completes at this edge
  logic        hit_status;   // address decodes to the status word
  logic        hit_mask;     // address decodes to the mask word
  logic        rd_clr;       // status read completes, clear what was shown
  logic        clr_a;        // clear slot A this edge
  logic        clr_b;        // clear slot B this edge
  logic        a_free;       // slot A can take the incoming event
  logic        b_free;       // slot B can take the incoming event
  logic [31:0] status_word;  // assembled status register

  // the two capture slots
  slot_if sa ();
  slot_if sb ();

  capture_slot u_slot_a
  (
    .clk     (clk),
    .reset_n (reset_n),
    .sl      (sa.store)
  );

  capture_slot u_slot_b
  (
    .clk     (clk),
    .reset_n (reset_n),
    .sl      (sb.store)
  );

  // apb phase and address decode
  assign setup       = psel & ~penable;
  assign access_done = psel & penable & pready_r;
  assign hit_status  = (paddr == STATUS_ADDR);
  assign hit_mask    = (paddr == MASK_ADDR);

  // only slots shown to software are cleared; an event loaded after
  // the setup sample is kept for the next read instead of vanishing
  assign rd_clr = access_done & ~pwrite & hit_status;
  assign clr_a  = rd_clr & snap_a_r;
  assign clr_b  = rd_clr & snap_b_r;

  // a slot being cleared on this edge counts as free
  assign a_free = ~sa.valid | clr_a;
  assign b_free = ~sb.valid | clr_b;

  // slot A first, then B; with both busy the event is lost
  assign sa.load      = drop_valid & a_free;
  assign sb.load      = drop_valid & ~a_free & b_free;
  assign sa.clear     = clr_a;
  assign sb.clear     = clr_b;
  assign sa.reason_in = drop_reason;
  assign sb.reason_in = drop_reason;
  assign sa.port_in   = drop_port;
  assign sb.port_in   = drop_port;

  // status word; reserved upper bits stay zero
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`DES_A_VALID_BIT] = sa.valid;
    status_word[`DES_A_PORT_MSB:`DES_A_PORT_LSB] = sa.port;
    status_word[`DES_A_REASON_MSB:`DES_A_REASON_LSB] = sa.reason;
    status_word[`DES_B_VALID_BIT] = sb.valid;
    status_word[`DES_B_PORT_MSB:`DES_B_PORT_LSB] = sb.port;
    status_word[`DES_B_REASON_MSB:`DES_B_REASON_LSB] = sb.reason;
  end

  // ready rises for the first access cycle only, so every transfer
  // completes with no wait state and still has registered outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pready_r <= 1'b0;
    else
      pready_r <= setup;
  end

  // unmapped addresses answer with an error and zero data
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pslverr_r <= 1'b0;
    else
      pslverr_r <= setup & ~hit_status & ~hit_mask;
  end

  // read data is sampled in setup and shown through the access phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata_r <= 32'h0000_0000;
    else if (setup & ~pwrite & hit_status)
      prdata_r <= status_word;
    else if (setup & ~pwrite & hit_mask)
      prdata_r <= {31'h0000_0000, mask_r};
    else if (setup)
      prdata_r <= 32'h0000_0000;
  end

  // remember which slots the pending read reported
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      snap_a_r <= 1'b0;
      snap_b_r <= 1'b0;
    end
    else if (setup & ~pwrite & hit_status)
    begin
      snap_a_r <= sa.valid;
      snap_b_r <= sb.valid;
    end
  end

  // mask write; status slots are never touched by it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mask_r <= `DEM_MASK_RESET;
    else if (access_done & pwrite & hit_mask & pstrb[0])
      mask_r <= pwdata[`DEM_MASK_BIT];
  end

  // interrupt request, one cycle behind the status it reflects
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else
      irq_r <= (sa.valid | sb.valid) & ~mask_r;
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign drop_irq = irq_r;

  // an empty slot A takes the event with its exact code and port
  chk_slot_a_first: assert property (
    @(posedge clk) disable iff (!reset_n)
    (drop_valid & ~sa.valid & ~rd_clr)
    |=> (sa.valid && sa.reason == $past(drop_reason)
         && sa.port == $past(drop_port)))
    else $error("event not captured in slot A");

  // with A busy, an empty slot B takes it and A stays as it was
  chk_slot_b_next: assert property (
    @(posedge clk) disable iff (!reset_n)
    (drop_valid & sa.valid & ~sb.valid & ~rd_clr)
    |=> (sb.valid && sb.reason == $past(drop_reason)
         && $stable(sa.reason) && $stable(sa.port)))
    else $error("second event not captured in slot B");

  // both slots full: the new event changes nothing
  chk_full_discard: assert property (
    @(posedge clk) disable iff (!reset_n)
    (drop_valid & sa.valid & sb.valid & ~rd_clr)
    |=> $stable(status_word))
    else $error("event overwrote a full slot");

  // interrupt follows the unmasked slot flags by one cycle
  chk_irq_follows: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 (drop_irq == ($past(sa.valid | sb.valid) & ~$past(mask_r))))
    else $error("interrupt does not follow slot flags and mask");

  // while masked for two cycles the interrupt stays low
  chk_mask_blocks: assert property (
    @(posedge clk) disable iff (!reset_n)
    mask_r [*2] |-> !drop_irq)
    else $error("interrupt raised while masked");

  // a mask write leaves captured status alone
  chk_mask_keeps: assert property (
    @(posedge clk) disable iff (!reset_n)
    (access_done & pwrite & hit_mask & ~drop_valid)
    |=> $stable(status_word))
    else $error("mask write disturbed status");

  // a completed status read empties the reported slots
  chk_read_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_clr & snap_a_r & snap_b_r & ~drop_valid)
    |=> (status_word == 32'h0000_0000))
    else $error("status read did not clear both slots");

  // an event arriving on the clearing edge is kept
  chk_set_wins: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_clr & snap_a_r & drop_valid) |=> sa.valid)
    else $error("event lost on the read clear edge");

  // empty slots show zero fields and reserved bits never rise
  chk_field_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    (~sa.valid |-> (status_word[`DES_A_REASON_MSB:`DES_A_PORT_LSB] == 6'h00))
    and (~sb.valid |-> (status_word[`DES_B_REASON_MSB:`DES_B_PORT_LSB] == 6'h00))
    and (status_word[`DES_RSVD_MSB:`DES_RSVD_LSB] == 18'h00000))
    else $error("fields set without their valid flag");

  // read data in the access phase matches the sampled status word
  chk_read_data: assert property (
    @(posedge clk) disable iff (!reset_n)
    (setup & ~pwrite & hit_status)
    |=> (pready && prdata == $past(status_word)))
    else $error("read data differs from status word");

  // no wait state: ready only in the cycle after setup
  chk_apb_wait: assert property (
    @(posedge clk) disable iff (!reset_n)
    setup |=> (pready ##1 !pready))
    else $error("ready not a single cycle after setup");

  // unmapped access answers with an error
  chk_unmapped_err: assert property (
    @(posedge clk) disable iff (!reset_n)
    (setup & ~hit_status & ~hit_mask) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access without error");

  // a filled slot A holds its capture until a read reports it
  chk_a_holds: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sa.valid & ~clr_a) |=> (sa.valid && $stable(sa.reason) && $stable(sa.port)))
    else $error("slot A changed while held");

  // the same for slot B; the two slots never disturb each other
  chk_b_holds: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sb.valid & ~clr_b) |=> (sb.valid && $stable(sb.reason) && $stable(sb.port)))
    else $error("slot B changed while held");

  // with both slots empty the event goes to A, never to B
  chk_a_before_b: assert property (
    @(posedge clk) disable iff (!reset_n)
    (drop_valid & ~sa.valid & ~sb.valid & ~rd_clr) |=> !sb.valid)
    else $error("event skipped slot A");

  // a set mask keeps the request low one cycle later
  chk_masked_low: assert property (
    @(posedge clk) disable iff (!reset_n)
    mask_r |=> !drop_irq)
    else $error("interrupt raised behind the mask");

  // unmasked pending status raises the request one cycle later
  chk_unmasked_high: assert property (
    @(posedge clk) disable iff (!reset_n)
    (~mask_r & (sa.valid | sb.valid)) |=> drop_irq)
    else $error("pending status without interrupt");

  // no pending status, no request
  chk_irq_low_empty: assert property (
    @(posedge clk) disable iff (!reset_n)
    ~(sa.valid | sb.valid) |=> !drop_irq)
    else $error("interrupt with both slots empty");

  // a strobed mask write takes the written bit
  chk_mask_load: assert property (
    @(posedge clk) disable iff (!reset_n)
    (access_done & pwrite & hit_mask & pstrb[0])
    |=> (mask_r == $past(pwdata[`DEM_MASK_BIT])))
    else $error("mask write not taken");

  // without its byte strobe a mask write changes nothing
  chk_strobe_ignored: assert property (
    @(posedge clk) disable iff (!reset_n)
    (access_done & pwrite & hit_mask & ~pstrb[0]) |=> $stable(mask_r))
    else $error("mask changed by an unstrobed write");

  // status is read-only: a write to it leaves both slots alone
  chk_status_readonly: assert property (
    @(posedge clk) disable iff (!reset_n)
    (access_done & pwrite & hit_status & ~drop_valid) |=> $stable(status_word))
    else $error("status changed by a write");

  // a mask read returns the mask bit and zeros above it
  chk_mask_readback: assert property (
    @(posedge clk) disable iff (!reset_n)
    (setup & ~pwrite & hit_mask) |=> (prdata == {31'h0000_0000, $past(mask_r)}))
    else $error("mask read data wrong");

  // mapped accesses never answer with an error
  chk_mapped_no_err: assert property (
    @(posedge clk) disable iff (!reset_n)
    (setup & (hit_status | hit_mask)) |=> !pslverr)
    else $error("error answer on a mapped register");

  // no setup, no ready in the next cycle
  chk_ready_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    !setup |=> !pready)
    else $error("ready without a setup cycle");
endmodule

// file: hdl/drop_capture_cfg.svh
`ifndef DROP_CAPTURE_CFG_SVH
`define DROP_CAPTURE_CFG_SVH

// register indices; the byte address is four times the index
`define DES_MASK_IDX      32'h0000_1C20
`define DES_STATUS_IDX    32'h0000_1C21
`define DES_IDX_SHIFT     2

// status word layout
`define DES_A_VALID_BIT   0
`define DES_A_PORT_LSB    1
`define DES_A_PORT_MSB    2
`define DES_A_REASON_LSB  3
`define DES_A_REASON_MSB  6
`define DES_B_VALID_BIT   7
`define DES_B_PORT_LSB    8
`define DES_B_PORT_MSB    9
`define DES_B_REASON_LSB  10
`define DES_B_REASON_MSB  13
`define DES_RSVD_LSB      14
`define DES_RSVD_MSB      31

// mask register layout and reset
`define DEM_MASK_BIT      0
`define DEM_MASK_RESET    1'h1

// drop reason codes
`define RSN_BCAST_LEVEL   4'h0
`define RSN_RED           4'h1
`define RSN_NO_BUFFER     4'h2
`define RSN_NO_DESC       4'h3
`define RSN_NO_DEST       4'h4
`define RSN_RX_ERROR      4'h5
`define RSN_DROP_LEVEL    4'h6
`define RSN_YELLOW        4'h9
`define RSN_CLEAR         4'h0

// source port codes
`define PORT_0            2'h0
`define PORT_1            2'h1
`define PORT_2            2'h2
`define PORT_RSVD         2'h3

`endif

// file: hdl/drop_capture_pkg.sv
`include "drop_capture_cfg.svh"

package drop_capture_pkg;

  // drop reason as delivered by the buffer manager
  typedef enum logic [3:0]
  {
    RSN_BCAST_LEVEL = `RSN_BCAST_LEVEL,
    RSN_RED         = `RSN_RED,
    RSN_NO_BUFFER   = `RSN_NO_BUFFER,
    RSN_NO_DESC     = `RSN_NO_DESC,
    RSN_NO_DEST     = `RSN_NO_DEST,
    RSN_RX_ERROR    = `RSN_RX_ERROR,
    RSN_DROP_LEVEL  = `RSN_DROP_LEVEL,
    RSN_YELLOW      = `RSN_YELLOW
  } reason_t;

  // source port of the dropped packet
  typedef enum logic [1:0]
  {
    SRC_PORT_0    = `PORT_0,
    SRC_PORT_1    = `PORT_1,
    SRC_PORT_2    = `PORT_2,
    SRC_PORT_RSVD = `PORT_RSVD
  } port_t;

endpackage

// file: hdl/slot_if.sv
`timescale 1ns/1ns

// one capture slot: load and clear from the controller, contents back
interface slot_if;
  import drop_capture_pkg::*;
  logic    load;       // take the incoming event this cycle
  logic    clear;      // empty the slot this cycle
  reason_t reason_in;  // incoming reason
  port_t   port_in;    // incoming source port
  logic    valid;      // slot holds a capture
  reason_t reason;     // stored reason
  port_t   port;       // stored source port

  modport ctrl
  (
    output load, clear, reason_in, port_in,
    input  valid, reason, port
  );

  modport store
  (
    input  load, clear, reason_in, port_in,
    output valid, reason, port
  );
endinterface

// file: hdl/capture_slot.sv
`timescale 1ns/1ns
`include "drop_capture_cfg.svh"

module capture_slot
(
  input wire logic clk,
  input wire logic reset_n,
  slot_if.store    sl
);
  import drop_capture_pkg::*;

  // load beats clear so an event landing on a read edge survives
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sl.valid  <= 1'b0;
      sl.reason <= reason_t'(`RSN_CLEAR);
      sl.port   <= port_t'(`PORT_0);
    end
    else if (sl.load)
    begin
      // code stored exactly as given, reserved ones included
      sl.valid  <= 1'b1;
      sl.reason <= sl.reason_in;
      sl.port   <= sl.port_in;
    end
    else if (sl.clear)
    begin
      // fields go to zero with the flag
      sl.valid  <= 1'b0;
      sl.reason <= reason_t'(`RSN_CLEAR);
      sl.port   <= port_t'(`PORT_0);
    end
  end
endmodule

// file: test/switch_drop_event_capture_tb.sv
`timescale 1ns/1ns
`include "drop_capture_cfg.svh"

module switch_drop_event_capture_tb;
  import drop_capture_pkg::*;

  typedef struct packed
  {
    logic [31:0] d;    // expected read data
    logic        e;    // expected error flag
    logic        rd;   // compare data only on reads
  } note_t;

  localparam logic [15:0] MASK_A = 16'(`DES_MASK_IDX << `DES_IDX_SHIFT);
  localparam logic [15:0] STAT_A = 16'(`DES_STATUS_IDX << `DES_IDX_SHIFT);

  logic        clk, reset_n, psel, penable, pwrite, drop_valid;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, drop_irq;
  reason_t     drop_reason;
  port_t       drop_port;
  note_t       notes[$];     // expected bus answers, oldest first
  int          n_errors;
  int          check_count;
  int          cycles;
  logic [31:0] rng;          // xorshift state
  logic [3:0]  codes[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};

  switch_drop_event_capture i_switch_drop_event_capture
  (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drop_valid(drop_valid), .drop_reason(drop_reason),
    .drop_port(drop_port), .drop_irq(drop_irq)
  );

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one apb transfer; the expected answer is noted for the monitor
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     input logic [3:0] st, input logic [31:0] exp_d, input logic exp_e);
    notes.push_back('{d: exp_d, e: exp_e, rd: ~wr});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk);
    penable <= 1'b1;
    // hold the request until pready is seen at an edge
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // up to three back-to-back drop events, one per cycle, each {reason, port}
  task automatic fire(input int n, input logic [5:0] e0, input logic [5:0] e1,
                      input logic [5:0] e2);
    logic [5:0] ev[3];
    ev[0] = e0;
    ev[1] = e1;
    ev[2] = e2;
    @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      drop_valid  <= 1'b1;
      drop_reason <= reason_t'(ev[i][5:2]);
      drop_port   <= port_t'(ev[i][1:0]);
      @(posedge clk);
    end
    drop_valid <= 1'b0;
  endtask

  // monitor: each completed access is matched against the oldest note
  always @(posedge clk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      note_t n;
      n = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, n.e});
      if (n.rd)
        check("prdata", prdata, n.d);
    end
  end

  // hang guard: far above the roughly 140 cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      n_errors++;
      $display("Error timeout expected done seen hang");
      tally_and_finish();
    end
  end

  initial
  begin
    logic [1:0]  p1, p2;
    logic [31:0] exp;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    rng = 32'h7A196D6A;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    drop_valid = 1'b0;
    drop_reason = RSN_BCAST_LEVEL;
    drop_port = SRC_PORT_0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;

    // reset values, strobe-less mask write, write to status, unmapped places
    apb(1'b0, MASK_A, 32'h0, 4'hF, 32'h1, 1'b0);
    apb(1'b1, MASK_A, 32'h0, 4'h0, 32'h0, 1'b0);
    apb(1'b0, MASK_A, 32'h0, 4'hF, 32'h1, 1'b0);
    apb(1'b1, STAT_A, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0);
    apb(1'b0, STAT_A, 32'h0, 4'hF, 32'h0, 1'b0);
    apb(1'b0, 16'h7088, 32'h0, 4'hF, 32'h0, 1'b1);
    apb(1'b1, 16'h7000, 32'h1, 4'hF, 32'h0, 1'b1);
    $display("test reset_and_map done");

    // every reason code into slot A with a random port, read clears it
    foreach (codes[i])
    begin
      p1 = 2'(xorshift() % 3);
      fire(1, {codes[i], p1}, 6'h00, 6'h00);
      apb(1'b0, STAT_A, 32'h0, 4'hF, {25'h0, codes[i], p1, 1'b1}, 1'b0);
      apb(1'b0, STAT_A, 32'h0, 4'hF, 32'h0, 1'b0);
    end
    $display("test reason_codes done");

    // three events back to back: A, then B, third discarded
    p1 = 2'(xorshift() % 3);
    p2 = 2'(xorshift() % 3);
    fire(3, {4'h6, p1}, {4'h9, p2}, {4'h3, 2'h2});
    exp = {18'h0, 4'h9, p2, 1'b1, 4'h6, p1, 1'b1};
    apb(1'b0, STAT_A, 32'h0, 4'hF, exp, 1'b0);
    apb(1'b0, STAT_A, 32'h0, 4'hF, 32'h0, 1'b0);
    $display("test double_buffer done");

    // interrupt: masked by default, rises two cycles after an unmasked event
    fire(1, {4'h2, 2'h1}, 6'h00, 6'h00);
    repeat (3) @(posedge clk);
    check("drop_irq", {31'h0, drop_irq}, 32'h0);
    apb(1'b1, MASK_A, 32'h0, 4'h1, 32'h0, 1'b0);
    repeat (3) @(posedge clk);
    check("drop_irq", {31'h0, drop_irq}, 32'h1);
    apb(1'b0, STAT_A, 32'h0, 4'hF, 32'h13, 1'b0);
    repeat (3) @(posedge clk);
    check("drop_irq", {31'h0, drop_irq}, 32'h0);
    fire(1, {4'h5, 2'h0}, 6'h00, 6'h00);
    #1;
    check("drop_irq", {31'h0, drop_irq}, 32'h0);
    @(posedge clk);
    #1;
    check("drop_irq", {31'h0, drop_irq}, 32'h1);
    // masking again drops the request but keeps the captured status
    apb(1'b1, MASK_A, 32'h1, 4'h1, 32'h0, 1'b0);
    repeat (3) @(posedge clk);
    check("drop_irq", {31'h0, drop_irq}, 32'h0);
    apb(1'b0, STAT_A, 32'h0, 4'hF, 32'h29, 1'b0);
    $display("test interrupt_mask done");

    // an event landing on the clearing edge of a read is kept in slot A
    fire(1, {4'h1, 2'h2}, 6'h00, 6'h00);
    fork
      apb(1'b0, STAT_A, 32'h0, 4'hF, 32'h0000_000D, 1'b0);
      begin
        @(posedge clk);
        fire(1, {4'h4, 2'h1}, 6'h00, 6'h00);
      end
    join
    apb(1'b0, STAT_A, 32'h0, 4'hF, 32'h0000_0023, 1'b0);
    $display("test clear_edge done");

    repeat (2) @(posedge clk);
    check("notes left", notes.size(), 32'h0);
    tally_and_finish();
  end
endmodule
